// [logic/sms_consts.svh]
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH
`define SMS_BITS 8
`define SMS_CNT_W 3
`define SMS_LAST_BIT 3'h7
`define SMS_DIV_W 8
`define SMS_CLOCK_PRESCALE_SEL_4 8'h02
`define SMS_CLOCK_PRESCALE_SEL_16 8'h08
`define SMS_CLOCK_PRESCALE_SEL_64 8'h20
`define SMS_CLOCK_PRESCALE_SEL_128 8'h40
`endif

// [logic/sms_pkg.sv]
package sms_pkg;
	typedef enum logic [1:0] {SMS_IDLE, SMS_SHIFT, SMS_DONE} sms_state_t;
	typedef logic [7:0] sms_byte_t;
endpackage : sms_pkg

// [logic/sms_pins_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sms_pins_if;
	logic sclk_raw;
	logic sel_raw;
	logic sdi_raw;
	logic sclk_s;
	logic sel_n_s;
	logic sdi_s;
	modport sync (input sclk_raw, sel_raw, sdi_raw,
		output sclk_s, sel_n_s, sdi_s);
	modport core (output sclk_raw, sel_raw, sdi_raw,
		input sclk_s, sel_n_s, sdi_s);
endinterface : sms_pins_if
`default_nettype wire

// [logic/sms_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module sms_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pins
	sms_pins_if.sync p
);
	logic [2:0] stage1_reg, stage1_next;
	logic [2:0] stage2_reg, stage2_next;
	always_comb begin
		stage1_next = {p.sclk_raw, p.sel_raw, p.sdi_raw};
		stage2_next = stage1_reg;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1_reg <= 3'h2;
			stage2_reg <= 3'h2;
		end else begin
			stage1_reg <= stage1_next;
			stage2_reg <= stage2_next;
		end
	end
	assign p.sclk_s = stage2_reg[2];
	assign p.sel_n_s = stage2_reg[1];
	assign p.sdi_s = stage2_reg[0];
endmodule : sms_sync
`default_nettype wire

// [logic/sms_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sms_consts.svh"
module sms_core import sms_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration
	input wire logic enable,
	input wire logic master_set,
	input wire logic master_clr,
	input wire logic [1:0] clock_prescale_sel,
	input wire logic clock_double,
	input wire logic bit_order_sel,
	input wire logic buffer_mode_en,
	input wire logic buffer_wait_receive,
	input wire logic select_pin_disable,
	input wire logic select_is_output,
	input wire logic miso_is_output,
	input wire logic general_irq_en,
	input wire logic transfer_done_irq_en,
	// Data access
	input wire logic data_wr,
	input wire logic [7:0] data_wdata,
	input wire logic data_rd,
	input wire logic flags_clr,
	// Status
	output logic master_mode,
	output logic [7:0] data_rdata,
	output logic rx_valid,
	output logic general_flag,
	output logic write_collision_flag,
	output logic tx_buffer_empty_flag,
	output logic transfer_done_flag,
	output logic irq,
	// Serial pins
	input wire logic sck_in,
	input wire logic ss_in,
	input wire logic mosi_in,
	input wire logic miso_in,
	output logic sck_out,
	output logic mosi_out,
	output logic miso_out,
	output logic miso_oe
);
	sms_pins_if pins();
	logic sdi_raw_pick;
	assign sdi_raw_pick = master_mode ? miso_in : mosi_in;
	assign pins.sclk_raw = sck_in;
	assign pins.sel_raw = ss_in;
	assign pins.sdi_raw = sdi_raw_pick;
	sms_sync u_sync (.clk(clk), .rst(rst), .p(pins));

	function automatic logic out_bit(input sms_byte_t v, input logic lsb);
		out_bit = lsb ? v[0] : v[7];
	endfunction : out_bit
	function automatic sms_byte_t shift_in(input sms_byte_t v,
		input logic lsb, input logic b);
		shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction : shift_in

	sms_state_t st_reg, st_next;
	sms_byte_t sh_reg, sh_next, txb_reg, txb_next, rx_byte;
	sms_byte_t rx0_reg, rx0_next, rx1_reg, rx1_next, mrx_reg, mrx_next;
	logic [1:0] rxn_reg, rxn_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [7:0] div_reg, div_next;
	logic txb_full_reg, txb_full_next, samp_reg, samp_next;
	logic master_reg, master_next;
	logic sclk_q_reg, sel_q_reg;
	logic sck_reg, sck_next, mosi_reg, mosi_next;
	logic miso_reg, miso_next, misooe_reg, misooe_next;
	logic if_reg, if_next, wcol_reg, wcol_next;
	logic dre_reg, dre_next, txc_reg, txc_next;
	logic irq_reg, irq_next;
	logic [7:0] div_lim;
	logic sclk_rise, sclk_fall, sel_rise, slave_sel, m_tick, done;

	always_comb begin
		unique case (clock_prescale_sel)
			2'h0: div_lim = `SMS_CLOCK_PRESCALE_SEL_4;
			2'h1: div_lim = `SMS_CLOCK_PRESCALE_SEL_16;
			2'h2: div_lim = `SMS_CLOCK_PRESCALE_SEL_64;
			2'h3: div_lim = `SMS_CLOCK_PRESCALE_SEL_128;
		endcase
		if (clock_double)
			div_lim = {1'b0, div_lim[7:1]};
	end

	// Edges found on synchronised copies only; external phases exceed two clocks
	assign sclk_rise = pins.sclk_s & ~sclk_q_reg;
	assign sclk_fall = ~pins.sclk_s & sclk_q_reg;
	assign sel_rise = pins.sel_n_s & ~sel_q_reg;
	assign slave_sel = ~master_reg & ~pins.sel_n_s;
	assign m_tick = master_reg && st_reg == SMS_SHIFT &&
		div_reg == div_lim - 8'h01;

	always_comb begin
		st_next = st_reg;
		sh_next = sh_reg;
		txb_next = txb_reg;
		rx0_next = rx0_reg;
		rx1_next = rx1_reg;
		rxn_next = rxn_reg;
		cnt_next = cnt_reg;
		div_next = (st_reg == SMS_SHIFT && master_reg) ?
			(m_tick ? 8'h00 : div_reg + 8'h01) : 8'h00;
		txb_full_next = txb_full_reg;
		// Input bit taken a cycle after the rise to cover synchroniser delay
		mrx_next = samp_reg ? shift_in(mrx_reg, bit_order_sel, pins.sdi_s) : mrx_reg;
		samp_next = 1'b0;
		rx_byte = sh_reg;
		master_next = master_reg;
		sck_next = sck_reg;
		mosi_next = mosi_reg;
		if_next = if_reg;
		wcol_next = wcol_reg;
		dre_next = dre_reg;
		txc_next = txc_reg;
		done = 1'b0;
		if (flags_clr) begin
			if_next = 1'b0;
			wcol_next = 1'b0;
			txc_next = 1'b0;
		end
		if (master_set)
			master_next = 1'b1;
		if (master_clr)
			master_next = 1'b0;
		if (data_rd && rxn_reg != 2'h0) begin
			rx0_next = buffer_mode_en ? rx1_reg : rx0_reg;
			rxn_next = rxn_reg - 2'h1;
		end
		if (!enable) begin
			st_next = SMS_IDLE;
			sck_next = 1'b0;
		end else if (master_reg) begin
			// Buffer-wait setting plays no part on the master path
			unique case (st_reg)
				SMS_IDLE: begin
					if (data_wr) begin
						sh_next = data_wdata;
						mosi_next = out_bit(data_wdata, bit_order_sel);
						cnt_next = 3'h0;
						st_next = SMS_SHIFT;
					end
				end
				SMS_SHIFT: begin
					if (m_tick) begin
						sck_next = ~sck_reg;
						if (!sck_reg) begin
							sh_next = shift_in(sh_reg, bit_order_sel, 1'b0);
							samp_next = 1'b1;
						end else if (cnt_reg == `SMS_LAST_BIT) begin
							st_next = SMS_DONE;
						end else begin
							cnt_next = cnt_reg + 3'h1;
							mosi_next = out_bit(sh_reg, bit_order_sel);
						end
					end
					if (data_wr) begin
						if (!buffer_mode_en) begin
							sh_next = data_wdata;
							wcol_next = 1'b1;
						end else if (dre_reg && !txb_full_reg) begin
							txb_next = data_wdata;
							txb_full_next = 1'b1;
							dre_next = 1'b0;
						end
					end
				end
				SMS_DONE: begin
					done = 1'b1;
					rx_byte = mrx_reg;
					if_next = 1'b1;
					if (buffer_mode_en && txb_full_reg) begin
						sh_next = txb_reg;
						txb_full_next = 1'b0;
						dre_next = 1'b1;
						mosi_next = out_bit(txb_reg, bit_order_sel);
						cnt_next = 3'h0;
						st_next = SMS_SHIFT;
					end else begin
						st_next = SMS_IDLE;
						if (buffer_mode_en)
							txc_next = 1'b1;
					end
				end
				default: st_next = SMS_IDLE;
			endcase
			// Select used only as an input with disable clear
			if (!select_pin_disable && !select_is_output &&
				!pins.sel_n_s) begin
				master_next = 1'b0;
				if_next = 1'b1;
				st_next = SMS_IDLE;
				sck_next = 1'b0;
			end
		end else begin
			sck_next = 1'b0;
			if (data_wr) begin
				if (st_reg == SMS_SHIFT && !buffer_mode_en)
					wcol_next = 1'b1;
				else if (buffer_mode_en) begin
					if (!txb_full_reg) begin
						txb_next = data_wdata;
						txb_full_next = 1'b1;
						dre_next = 1'b0;
					end
				end else
					sh_next = data_wdata;
			end
			if (pins.sel_n_s) begin
				st_next = SMS_IDLE;
				cnt_next = 3'h0;
				if (buffer_mode_en && txb_full_reg && st_reg == SMS_IDLE) begin
					sh_next = txb_reg;
					txb_full_next = 1'b0;
					dre_next = 1'b1;
				end
			end else if (sclk_rise) begin
				rx_byte = shift_in(sh_reg, bit_order_sel, pins.sdi_s);
				sh_next = rx_byte;
				st_next = SMS_SHIFT;
				if (cnt_reg == `SMS_LAST_BIT) begin
					done = 1'b1;
					if_next = 1'b1;
					st_next = SMS_IDLE;
					cnt_next = 3'h0;
					if (buffer_mode_en && txb_full_reg) begin
						sh_next = txb_reg;
						txb_full_next = 1'b0;
						dre_next = 1'b1;
					end
				end else
					cnt_next = cnt_reg + 3'h1;
			end
		end
		if (done) begin
			if (buffer_mode_en) begin
				if (rxn_next == 2'h2)
					rx1_next = rx_byte;
				else if (rxn_next == 2'h1) begin
					rx1_next = rx_byte;
					rxn_next = 2'h2;
				end else begin
					rx0_next = rx_byte;
					rxn_next = 2'h1;
				end
			end else begin
				rx0_next = rx_byte;
				rxn_next = 2'h1;
			end
		end
		irq_next = (if_next & general_irq_en) |
			(txc_next & transfer_done_irq_en);
		miso_next = out_bit(sh_next, bit_order_sel);
		misooe_next = slave_sel & miso_is_output & enable;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= SMS_IDLE;
			sh_reg <= 8'h00;
			txb_reg <= 8'h00;
			rx0_reg <= 8'h00;
			rx1_reg <= 8'h00;
			rxn_reg <= 2'h0;
			cnt_reg <= 3'h0;
			div_reg <= 8'h00;
			txb_full_reg <= 1'b0;
			mrx_reg <= 8'h00;
			samp_reg <= 1'b0;
			master_reg <= 1'b0;
			sclk_q_reg <= 1'b0;
			sel_q_reg <= 1'b1;
			sck_reg <= 1'b0;
			mosi_reg <= 1'b0;
			miso_reg <= 1'b0;
			misooe_reg <= 1'b0;
			if_reg <= 1'b0;
			wcol_reg <= 1'b0;
			dre_reg <= 1'b1;
			txc_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			sh_reg <= sh_next;
			txb_reg <= txb_next;
			rx0_reg <= rx0_next;
			rx1_reg <= rx1_next;
			rxn_reg <= rxn_next;
			cnt_reg <= cnt_next;
			div_reg <= div_next;
			txb_full_reg <= txb_full_next;
			mrx_reg <= mrx_next;
			samp_reg <= samp_next;
			master_reg <= master_next;
			sclk_q_reg <= pins.sclk_s;
			sel_q_reg <= pins.sel_n_s;
			sck_reg <= sck_next;
			mosi_reg <= mosi_next;
			miso_reg <= miso_next;
			misooe_reg <= misooe_next;
			if_reg <= if_next;
			wcol_reg <= wcol_next;
			dre_reg <= dre_next;
			txc_reg <= txc_next;
			irq_reg <= irq_next;
		end
	end

	assign master_mode = master_reg;
	assign data_rdata = rx0_reg;
	assign rx_valid = rxn_reg != 2'h0;
	assign general_flag = if_reg;
	assign write_collision_flag = wcol_reg;
	assign tx_buffer_empty_flag = dre_reg;
	assign transfer_done_flag = txc_reg;
	assign irq = irq_reg;
	assign sck_out = sck_reg;
	assign mosi_out = mosi_reg;
	assign miso_out = miso_reg;
	assign miso_oe = misooe_reg;
endmodule : sms_core
`default_nettype wire

// [tb/sms_spi_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module sms_spi_dev (
	// Bus side
	input wire logic sck,
	input wire logic sel_n,
	input wire logic mosi,
	output logic miso,
	// Bench side
	input wire logic [7:0] tx,
	output logic [7:0] rx
);
	logic [7:0] sh;
	int n;
	// Deselected, the line shows the inverse so a stale bit never matches
	assign miso = sel_n ? ~sh[7] : sh[7];
	always @(negedge sel_n) begin
		sh = tx;
		n = 0;
	end
	always @(posedge sck) if (!sel_n) rx = {rx[6:0], mosi};
	always @(negedge sck) if (!sel_n) begin
		n = n + 1;
		sh = (n % 8 == 0) ? tx : {sh[6:0], 1'b0};
	end
endmodule : sms_spi_dev
`default_nettype wire

// [tb/sms_core_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module sms_core_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Controls
	input wire logic master_clr,
	input wire logic select_pin_disable,
	input wire logic select_is_output,
	input wire logic miso_is_output,
	input wire logic general_irq_en,
	input wire logic buffer_mode_en,
	input wire logic data_wr,
	input wire logic ss_in,
	// Status and pins
	input wire logic master_mode,
	input wire logic general_flag,
	input wire logic write_collision_flag,
	input wire logic transfer_done_flag,
	input wire logic irq,
	input wire logic sck_out,
	input wire logic miso_oe
);
	logic [3:0] cnt_reg, cnt_next;
	logic sck_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Serial clock rises since the last data write
	always_comb begin
		cnt_next = cnt_reg;
		if (data_wr)
			cnt_next = 4'h0;
		else if (sck_out && !sck_reg)
			cnt_next = cnt_reg + 4'h1;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 4'h0;
			sck_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			sck_reg <= sck_out;
		end
	end
	AST_BYTE: assert property ($rose(general_flag) && master_mode
		&& !buffer_mode_en && !write_collision_flag |-> cnt_reg == 4'h8)
		else $error("byte not eight clocks");
	AST_IRQ: assert property (general_flag && general_irq_en
		|-> ##[0:1] irq) else $error("irq missing");
	AST_OE_ON: assert property ($rose(miso_oe)
		|-> miso_is_output && !master_mode) else $error("bad oe");
	AST_OE_OFF: assert property (ss_in [*5] |-> !miso_oe)
		else $error("oe while deselected");
	AST_FORCE: assert property ((master_mode && !select_pin_disable
		&& !select_is_output && !ss_in) [*3] |=> !master_mode)
		else $error("master kept");
	AST_FORCE_FLAG: assert property ($fell(master_mode)
		&& !$past(master_clr) |-> ##[0:1] general_flag)
		else $error("flag missing");
	AST_HOLD: assert property ((select_pin_disable || select_is_output)
		&& master_mode && !master_clr |=> master_mode)
		else $error("master lost");
	AST_WCOL: assert property ($rose(write_collision_flag)
		|-> $past(data_wr) || $past(data_wr, 2)) else $error("bad wcol");
	AST_DONE: assert property ($rose(transfer_done_flag)
		|-> buffer_mode_en) else $error("bad done flag");
endmodule : sms_core_sva
bind sms_core sms_core_sva sms_core_sva_inst (.clk, .rst, .master_clr,
	.select_pin_disable, .select_is_output, .miso_is_output,
	.general_irq_en, .buffer_mode_en, .data_wr, .ss_in, .master_mode,
	.general_flag, .write_collision_flag, .transfer_done_flag, .irq,
	.sck_out, .miso_oe);
`default_nettype wire

// [tb/tb_sms_core.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_sms_core;
	import sms_pkg::*;
	logic clk = 0, rst = 1;
	logic enable, master_set, master_clr, clock_double, bit_order_sel;
	logic buffer_mode_en, buffer_wait_receive, select_pin_disable;
	logic select_is_output, miso_is_output, general_irq_en;
	logic transfer_done_irq_en, data_wr, data_rd, flags_clr;
	logic sck_in, ss_in, mosi_in, miso_in, dev_sel_n;
	logic master_mode, rx_valid, general_flag, write_collision_flag;
	logic tx_buffer_empty_flag, transfer_done_flag, irq;
	logic sck_out, mosi_out, miso_out, miso_oe;
	logic [1:0] clock_prescale_sel;
	sms_byte_t data_wdata, data_rdata, dev_tx, dev_rx, got;
	sms_byte_t hp [4] = '{8'h02, 8'h08, 8'h20, 8'h40};
	int fail_count = 0, check_count = 0;
	sms_core sms_core_inst (.clk, .rst, .enable, .master_set, .master_clr,
		.clock_prescale_sel, .clock_double, .bit_order_sel, .buffer_mode_en,
		.buffer_wait_receive, .select_pin_disable, .select_is_output,
		.miso_is_output, .general_irq_en, .transfer_done_irq_en, .data_wr,
		.data_wdata, .data_rd, .flags_clr, .master_mode, .data_rdata,
		.rx_valid, .general_flag, .write_collision_flag,
		.tx_buffer_empty_flag, .transfer_done_flag, .irq, .sck_in, .ss_in,
		.mosi_in, .miso_in, .sck_out, .mosi_out, .miso_out, .miso_oe);
	sms_spi_dev sms_spi_dev_inst (.sck(sck_out), .sel_n(dev_sel_n),
		.mosi(mosi_out), .miso(miso_in), .tx(dev_tx), .rx(dev_rx));
	always #2.5 clk = ~clk;
	task automatic chk(input string what, input sms_byte_t seen, exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic pulse(ref logic s);
		s = 1;
		cyc(1);
		s = 0;
	endtask : pulse
	task automatic wr(input sms_byte_t b);
		data_wdata = b;
		pulse(data_wr);
	endtask : wr
	task automatic rd(input sms_byte_t exp);
		chk("rdata", data_rdata, exp);
		pulse(data_rd);
	endtask : rd
	task automatic wait_flag(ref logic f);
		for (int i = 0; i < 4000 && f !== 1'b1; i++) cyc(1);
		chk("flag", {7'h0, f}, 8'h01);
	endtask : wait_flag
	// Half period of 32 ns keeps each phase above two system clocks
	task automatic sx(input sms_byte_t tx, exp, input int nb);
		ss_in = 0;
		#64;
		for (int i = 0; i < nb; i++) begin
			mosi_in = tx[7 - i];
			#32 got = {got[6:0], miso_out};
			sck_in = 1;
			#32 sck_in = 0;
		end
		#32 ss_in = 1;
		mosi_in = ~mosi_in;
		if (nb == 8) chk("miso", got, exp);
		cyc(3);
	endtask : sx
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	initial begin
		#400000;
		fail_count++;
		end_sim();
	end
	initial begin
		{enable, master_set, master_clr, clock_double, bit_order_sel} = '0;
		{buffer_mode_en, buffer_wait_receive, select_pin_disable} = '0;
		{select_is_output, transfer_done_irq_en, data_wr, data_rd} = '0;
		{flags_clr, sck_in, mosi_in, clock_prescale_sel, data_wdata} = '0;
		{ss_in, dev_sel_n, miso_is_output, general_irq_en} = 4'hf;
		dev_tx = 8'ha5;
		cyc(10);
		rst = 0;
		enable = 1;
		cyc(3);
		pulse(master_set);
		dev_sel_n = 0;
		wr(8'h3c);
		wait_flag(general_flag);
		chk("irq", {7'h0, irq}, 8'h01);
		chk("dev", dev_rx, 8'h3c);
		rd(8'ha5);
		pulse(flags_clr);
		bit_order_sel = 1;
		for (int i = 0; i < 8; i++) begin
			{clock_double, clock_prescale_sel} = 3'(i);
			wr(8'h01);
			for (int n = 0; n < 300 && !sck_out; n++) cyc(1);
			for (int n = 0; n < 300; n++) begin
				cyc(1);
				if (sck_out !== 1'b1) begin
					chk("half", 8'(n + 1), hp[i % 4] >> (i / 4));
					break;
				end
			end
			wait_flag(general_flag);
			chk("dev", dev_rx, 8'h80);
			pulse(flags_clr);
		end
		{bit_order_sel, clock_double, clock_prescale_sel} = '0;
		wr(8'h11);
		cyc(4);
		wr(8'h22);
		wait_flag(general_flag);
		chk("wcol", {7'h0, write_collision_flag}, 8'h01);
		pulse(flags_clr);
		select_pin_disable = 1;
		ss_in = 0;
		cyc(6);
		chk("master", {7'h0, master_mode}, 8'h01);
		{select_pin_disable, select_is_output} = 2'b01;
		cyc(6);
		chk("master", {7'h0, master_mode}, 8'h01);
		ss_in = 1;
		cyc(4);
		select_is_output = 0;
		ss_in = 0;
		cyc(6);
		chk("master", {7'h0, master_mode}, 8'h00);
		chk("gflag", {7'h0, general_flag}, 8'h01);
		ss_in = 1;
		pulse(flags_clr);
		cyc(3);
		pulse(master_set);
		{buffer_mode_en, buffer_wait_receive} = 2'b11;
		data_wdata = 8'h55;
		data_wr = 1;
		cyc(1);
		data_wdata = 8'h66;
		cyc(1);
		data_wr = 0;
		chk("empty", {7'h0, tx_buffer_empty_flag}, 8'h00);
		wait_flag(transfer_done_flag);
		chk("dev", dev_rx, 8'h66);
		rd(8'ha5);
		rd(8'ha5);
		chk("valid", {7'h0, rx_valid}, 8'h00);
		buffer_mode_en = 0;
		dev_sel_n = 1;
		pulse(flags_clr);
		pulse(master_clr);
		wr(8'h96);
		sx(8'h69, 8'h96, 8);
		wait_flag(general_flag);
		rd(8'h69);
		chk("oe", {7'h0, miso_oe}, 8'h00);
		pulse(flags_clr);
		wr(8'h5a);
		fork
			sx(8'h0f, 8'h5a, 8);
			begin
				#300;
				cyc(1);
				wr(8'hff);
			end
		join
		chk("wcol", {7'h0, write_collision_flag}, 8'h01);
		rd(8'h0f);
		pulse(flags_clr);
		sx(8'hff, 8'h00, 4);
		cyc(4);
		chk("gflag", {7'h0, general_flag}, 8'h00);
		wr(8'hc3);
		sx(8'h3c, 8'hc3, 8);
		wait_flag(general_flag);
		rd(8'h3c);
		end_sim();
	end
endmodule : tb_sms_core
`default_nettype wire
